// [src/rmcr_pkg.sv]
package rmcr_pkg;
   // Register offsets
   localparam logic [7:0] OFS_DATA_MOD = 8'h01;
   localparam logic [7:0] OFS_FREQ_DEV = 8'h02;
   localparam logic [7:0] OFS_BIT_RATE = 8'h03;
   localparam logic [7:0] OFS_FLOOR = 8'h04;
   localparam logic [7:0] OFS_FIFO = 8'h05;
   // Reset values
   localparam logic [7:0] RST_DATA_MOD = 8'h88;
   localparam logic [7:0] RST_FREQ_DEV = 8'h03;
   localparam logic [7:0] RST_BIT_RATE = 8'h07;
   localparam logic [7:0] RST_FLOOR = 8'h0c;
   localparam logic [7:0] RST_FIFO = 8'h0f;
   // Field positions
   localparam int MODULATION_SELECT_LSB = 6;
   localparam int DOP_LOWER_POS = 5;
   localparam int OOK_THRESHOLD_TYPE_LSB = 3;
   localparam int DOP_UPPER_POS = 2;
   localparam int IFATT_LSB = 0;
   localparam int RATE_RSVD_POS = 7;
   localparam int FIFO_DEPTH_SELECT_LSB = 6;
   localparam int FTHR_LSB = 0;
   // Field codes
   localparam logic [1:0] MOD_CODE_FSK = 2'h2;
   localparam logic [1:0] MOD_CODE_OOK = 2'h1;
   localparam logic [1:0] OOK_CODE_FIXED = 2'h0;
   localparam logic [1:0] OOK_CODE_PEAK = 2'h1;
   localparam logic [1:0] OOK_CODE_AVG = 2'h2;
   // Scaling
   localparam logic [3:0] DEV_SHIFT = 4'h5;
   localparam logic [3:0] RATE_SHIFT = 4'h6;
   localparam logic [4:0] IF_STEP_HALF_DB = 5'h09;
   localparam logic [6:0] FIFO_STEP_BYTES = 7'h10;

   typedef enum logic [1:0] {RMCR_MOD_RSVD, RMCR_MOD_FSK, RMCR_MOD_OOK} rmcr_mod_t;
   typedef enum logic [1:0] {RMCR_DOP_CONT, RMCR_DOP_BUF, RMCR_DOP_PKT} rmcr_dop_t;
   typedef enum logic [1:0] {
      RMCR_OOK_FIXED, RMCR_OOK_PEAK, RMCR_OOK_AVG, RMCR_OOK_RSVD
   } rmcr_ook_t;
   typedef enum logic [1:0] {RMCR_RADIO_STBY, RMCR_RADIO_TX, RMCR_RADIO_RX} rmcr_radio_t;
endpackage : rmcr_pkg

// [src/rmcr_fifo_if.sv]
`timescale 1ns/1ps
interface rmcr_fifo_if;
   import rmcr_pkg::*;
   logic [5:0] threshold;
   logic [6:0] fill;
   rmcr_radio_t radio_mode;
   logic event_level;
   modport cfg_side (output threshold, output fill, output radio_mode, input event_level);
   modport thr_side (input threshold, input fill, input radio_mode, output event_level);
endinterface : rmcr_fifo_if

// [src/rmcr_fifo_thr.sv]
`timescale 1ns/1ps
module rmcr_fifo_thr (
   rmcr_fifo_if.thr_side fifo_if
);
   import rmcr_pkg::*;
   wire above_thr;
   // Event meaning depends on the radio mode
   assign above_thr = fifo_if.fill > {1'b0, fifo_if.threshold};
   always_comb begin
      unique case (fifo_if.radio_mode)
         RMCR_RADIO_TX: fifo_if.event_level = !above_thr;
         RMCR_RADIO_RX: fifo_if.event_level = above_thr;
         default: fifo_if.event_level = 1'b0;
      endcase
   end
endmodule : rmcr_fifo_thr

// [src/radio_modem_config_regs.sv]
`timescale 1ns/1ps
module radio_modem_config_regs (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire rmcr_pkg::rmcr_radio_t radio_mode_in,
   input wire logic [6:0] fifo_fill_in,
   output rmcr_pkg::rmcr_mod_t modulation_out,
   output logic mod_reserved_out,
   output rmcr_pkg::rmcr_dop_t data_op_mode_out,
   output rmcr_pkg::rmcr_ook_t ook_threshold_type_out,
   output logic [1:0] if_attenuation_out,
   output logic [4:0] if_atten_half_db_out,
   output logic [7:0] deviation_value_out,
   output logic [13:0] dev_divisor_out,
   output logic [6:0] rate_divider_value_out,
   output logic [13:0] bit_period_out,
   output logic [7:0] floor_threshold_value_out,
   output logic [6:0] fifo_depth_bytes_out,
   output logic [5:0] fifo_fill_threshold_out,
   output logic fifo_thr_event_out
);
   import rmcr_pkg::*;

   // Divisor (value + 1) scaled by a power of two
   function automatic logic [13:0] scaled_div(input logic [7:0] v, input logic [3:0] sh);
      scaled_div = ({6'h00, v} + 14'h0001) << sh;
   endfunction : scaled_div

   logic [7:0] data_mod_ff;
   logic [7:0] freq_dev_ff;
   logic [7:0] bit_rate_ff;
   logic [7:0] floor_ff;
   logic [7:0] fifo_cfg_ff;
   logic [7:0] nxt_data_mod;
   logic [7:0] nxt_freq_dev;
   logic [7:0] nxt_bit_rate;
   logic [7:0] nxt_floor;
   logic [7:0] nxt_fifo_cfg;
   logic [7:0] nxt_rdata;

   rmcr_mod_t nxt_modulation;
   rmcr_dop_t nxt_data_op;
   rmcr_ook_t nxt_ook_type;
   logic [4:0] nxt_if_half_db;
   logic [13:0] nxt_dev_divisor;
   logic [13:0] nxt_bit_period;
   logic [6:0] nxt_fifo_depth;

   // Write decode
   wire sel_data_mod = wr_in && (addr_in == OFS_DATA_MOD);
   wire sel_freq_dev = wr_in && (addr_in == OFS_FREQ_DEV);
   wire sel_bit_rate = wr_in && (addr_in == OFS_BIT_RATE);
   wire sel_floor = wr_in && (addr_in == OFS_FLOOR);
   wire sel_fifo_cfg = wr_in && (addr_in == OFS_FIFO);

   assign nxt_data_mod = sel_data_mod ? wdata_in : data_mod_ff;
   assign nxt_freq_dev = sel_freq_dev ? wdata_in : freq_dev_ff;
   // Reserved rate bit is held at zero
   assign nxt_bit_rate = sel_bit_rate ? {1'b0, wdata_in[6:0]} : bit_rate_ff;
   assign nxt_floor = sel_floor ? wdata_in : floor_ff;
   assign nxt_fifo_cfg = sel_fifo_cfg ? wdata_in : fifo_cfg_ff;

   // Field slices of the next register values
   wire [1:0] nxt_mod_code = nxt_data_mod[MODULATION_SELECT_LSB +: 2];
   wire nxt_dop_lower = nxt_data_mod[DOP_LOWER_POS];
   wire nxt_dop_upper = nxt_data_mod[DOP_UPPER_POS];
   wire [1:0] nxt_ook_code = nxt_data_mod[OOK_THRESHOLD_TYPE_LSB +: 2];
   wire [1:0] nxt_if_code = nxt_data_mod[IFATT_LSB +: 2];
   wire [1:0] nxt_fifo_depth_select = nxt_fifo_cfg[FIFO_DEPTH_SELECT_LSB +: 2];
   wire [5:0] nxt_fthr = nxt_fifo_cfg[FTHR_LSB +: 6];

   assign nxt_modulation = (nxt_mod_code == MOD_CODE_FSK) ? RMCR_MOD_FSK :
                           (nxt_mod_code == MOD_CODE_OOK) ? RMCR_MOD_OOK :
                           RMCR_MOD_RSVD;
   assign nxt_data_op = nxt_dop_upper ? RMCR_DOP_PKT :
                        nxt_dop_lower ? RMCR_DOP_BUF : RMCR_DOP_CONT;
   assign nxt_ook_type = (nxt_ook_code == OOK_CODE_FIXED) ? RMCR_OOK_FIXED :
                         (nxt_ook_code == OOK_CODE_PEAK) ? RMCR_OOK_PEAK :
                         (nxt_ook_code == OOK_CODE_AVG) ? RMCR_OOK_AVG : RMCR_OOK_RSVD;
   assign nxt_if_half_db = {3'h0, nxt_if_code} * IF_STEP_HALF_DB;
   assign nxt_dev_divisor = scaled_div(nxt_freq_dev, DEV_SHIFT);
   assign nxt_bit_period = scaled_div({1'b0, nxt_bit_rate[6:0]}, RATE_SHIFT);
   assign nxt_fifo_depth = ({5'h00, nxt_fifo_depth_select} + 7'h01) * FIFO_STEP_BYTES;

   // Read mux, unmapped offsets read zero
   always_comb begin
      unique case (addr_in)
         OFS_DATA_MOD: nxt_rdata = data_mod_ff;
         OFS_FREQ_DEV: nxt_rdata = freq_dev_ff;
         OFS_BIT_RATE: nxt_rdata = bit_rate_ff;
         OFS_FLOOR: nxt_rdata = floor_ff;
         OFS_FIFO: nxt_rdata = fifo_cfg_ff;
         default: nxt_rdata = 8'h00;
      endcase
   end

   // FIFO threshold event
   rmcr_fifo_if fifo_if ();
   assign fifo_if.threshold = fifo_cfg_ff[FTHR_LSB +: 6];
   assign fifo_if.fill = fifo_fill_in;
   assign fifo_if.radio_mode = radio_mode_in;

   rmcr_fifo_thr u_fifo_thr (
      .fifo_if(fifo_if.thr_side)
   );

   // Configuration registers
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         data_mod_ff <= RST_DATA_MOD;
         freq_dev_ff <= RST_FREQ_DEV;
         bit_rate_ff <= RST_BIT_RATE;
         floor_ff <= RST_FLOOR;
         fifo_cfg_ff <= RST_FIFO;
      end else begin
         data_mod_ff <= nxt_data_mod;
         freq_dev_ff <= nxt_freq_dev;
         bit_rate_ff <= nxt_bit_rate;
         floor_ff <= nxt_floor;
         fifo_cfg_ff <= nxt_fifo_cfg;
      end
   end

   // Read data stands one cycle only
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= rd_in ? nxt_rdata : 8'h00;
      end
   end

   // Decoded controls, aligned with the registers
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         modulation_out <= RMCR_MOD_FSK;
         mod_reserved_out <= 1'b0;
         data_op_mode_out <= RMCR_DOP_CONT;
         ook_threshold_type_out <= RMCR_OOK_PEAK;
         if_attenuation_out <= 2'h0;
         if_atten_half_db_out <= 5'h00;
      end else begin
         modulation_out <= nxt_modulation;
         mod_reserved_out <= (nxt_modulation == RMCR_MOD_RSVD);
         data_op_mode_out <= nxt_data_op;
         ook_threshold_type_out <= nxt_ook_type;
         if_attenuation_out <= nxt_if_code;
         if_atten_half_db_out <= nxt_if_half_db;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         deviation_value_out <= RST_FREQ_DEV;
         dev_divisor_out <= scaled_div(RST_FREQ_DEV, DEV_SHIFT);
         rate_divider_value_out <= RST_BIT_RATE[6:0];
         bit_period_out <= scaled_div({1'b0, RST_BIT_RATE[6:0]}, RATE_SHIFT);
      end else begin
         deviation_value_out <= nxt_freq_dev;
         dev_divisor_out <= nxt_dev_divisor;
         rate_divider_value_out <= nxt_bit_rate[6:0];
         bit_period_out <= nxt_bit_period;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         floor_threshold_value_out <= RST_FLOOR;
         fifo_depth_bytes_out <= FIFO_STEP_BYTES;
         fifo_fill_threshold_out <= RST_FIFO[5:0];
         fifo_thr_event_out <= 1'b0;
      end else begin
         floor_threshold_value_out <= nxt_floor;
         fifo_depth_bytes_out <= nxt_fifo_depth;
         fifo_fill_threshold_out <= nxt_fthr;
         fifo_thr_event_out <= fifo_if.event_level;
      end
   end

   // Checks
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_dev_write;
      wr_in && (addr_in == OFS_FREQ_DEV);
   endsequence
   sequence s_dev_read;
      rd_in && !wr_in && (addr_in == OFS_FREQ_DEV);
   endsequence

   a_write_read_back: assert property (
      s_dev_write ##1 s_dev_read |=> rdata_out == $past(wdata_in, 2))
      else $error("Deviation register did not read back written value");

   a_read_one_cycle: assert property (
      !rd_in |=> rdata_out == 8'h00)
      else $error("Read data present without a read");

   a_mod_select: assert property (
      ##1 ((data_mod_ff[7:6] == 2'h2) == (modulation_out == RMCR_MOD_FSK))
      && ((data_mod_ff[7:6] == 2'h1) == (modulation_out == RMCR_MOD_OOK)))
      else $error("Modulation select mismatch");

   a_data_op_mode: assert property (
      data_mod_ff[2] ? (data_op_mode_out == RMCR_DOP_PKT)
      : (data_op_mode_out == (data_mod_ff[5] ? RMCR_DOP_BUF : RMCR_DOP_CONT)))
      else $error("Data operation mode mismatch");

   a_ook_type_sel: assert property (
      (data_mod_ff[4:3] == 2'h2) == (ook_threshold_type_out == RMCR_OOK_AVG))
      else $error("OOK threshold type mismatch");

   a_if_atten_steps: assert property (
      if_atten_half_db_out == {3'h0, data_mod_ff[1:0]} * 5'h09)
      else $error("IF attenuation mismatch");

   a_dev_divisor: assert property (
      dev_divisor_out == ({6'h00, freq_dev_ff} + 14'h0001) * 14'h0020)
      else $error("Deviation divisor mismatch");

   a_rate_period: assert property (
      bit_period_out == ({7'h00, bit_rate_ff[6:0]} + 14'h0001) * 14'h0040)
      else $error("Bit period mismatch");

   a_rate_rsvd_zero: assert property (
      sel_bit_rate |=> bit_rate_ff[7] == 1'b0 && bit_rate_ff[6:0] == $past(wdata_in[6:0]))
      else $error("Bit rate register write wrong");

   a_floor_value: assert property (
      sel_floor |=> floor_threshold_value_out == $past(wdata_in))
      else $error("Floor threshold not updated");

   a_fifo_depth_map: assert property (
      fifo_depth_bytes_out == ({5'h00, fifo_cfg_ff[7:6]} + 7'h01) * 7'h10)
      else $error("FIFO depth mismatch");

   a_fifo_thr_stby: assert property (
      radio_mode_in == RMCR_RADIO_STBY |=> !fifo_thr_event_out)
      else $error("Threshold event in standby");

   a_fifo_thr_rx: assert property (
      radio_mode_in == RMCR_RADIO_RX && fifo_fill_in > {1'b0, fifo_cfg_ff[5:0]}
      |=> fifo_thr_event_out)
      else $error("Threshold event missing in receive");

   a_fifo_thr_low: assert property (
      radio_mode_in == RMCR_RADIO_RX && fifo_fill_in <= {1'b0, fifo_cfg_ff[5:0]}
      |=> !fifo_thr_event_out)
      else $error("Threshold event raised below level in receive");

   a_fifo_thr_tx: assert property (
      radio_mode_in == RMCR_RADIO_TX && fifo_fill_in <= {1'b0, fifo_cfg_ff[5:0]}
      |=> fifo_thr_event_out)
      else $error("Threshold event missing in transmit");

   a_mod_reserved: assert property (
      mod_reserved_out == (data_mod_ff[7:6] == 2'h0 || data_mod_ff[7:6] == 2'h3))
      else $error("Reserved modulation flag mismatch");

   a_ook_fixed_peak: assert property (
      ((data_mod_ff[4:3] == 2'h0) == (ook_threshold_type_out == RMCR_OOK_FIXED))
      && ((data_mod_ff[4:3] == 2'h1) == (ook_threshold_type_out == RMCR_OOK_PEAK)))
      else $error("OOK fixed or peak type mismatch");

   a_if_field: assert property (
      if_attenuation_out == data_mod_ff[1:0])
      else $error("IF attenuation field mismatch");

   a_dev_value_out: assert property (
      deviation_value_out == freq_dev_ff)
      else $error("Deviation value output mismatch");

   a_rate_value_out: assert property (
      rate_divider_value_out == bit_rate_ff[6:0])
      else $error("Rate value output mismatch");

   a_fifo_thr_field: assert property (
      fifo_fill_threshold_out == fifo_cfg_ff[5:0])
      else $error("FIFO threshold field mismatch");

   a_floor_read: assert property (
      rd_in && (addr_in == OFS_FLOOR) |=> rdata_out == $past(floor_ff))
      else $error("Floor register read back wrong");

   a_reset_values: assert property (
      @(posedge mclk_in) disable iff (1'b0)
      rst_in |=> freq_dev_ff == 8'h03 && bit_rate_ff == 8'h07
      && floor_ff == 8'h0c && fifo_cfg_ff == 8'h0f && fifo_fill_threshold_out == 6'h0f)
      else $error("Register reset value wrong");
endmodule : radio_modem_config_regs

// [verif/rmcr_host_model.sv]
`timescale 1ns/1ps
module rmcr_host_model (
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   import rmcr_pkg::*;
   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // Idle bus shows inverted last value
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= (a == OFS_BIT_RATE) ? {1'b0, d[6:0]} : d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask : write_reg
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      #1;
      d = rdata_in;
   endtask : read_reg
   // Write followed by a read with no idle cycle between
   task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= (a == OFS_BIT_RATE) ? {1'b0, d[6:0]} : d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
      #1;
      q = rdata_in;
   endtask : write_read
endmodule : rmcr_host_model

// [verif/radio_modem_config_regs_test.sv]
`timescale 1ns/1ps
module radio_modem_config_regs_test;
   import rmcr_pkg::*;
   logic mclk_in;
   logic rst_in;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   rmcr_radio_t radio_mode;
   logic [6:0] fifo_fill;
   rmcr_mod_t modulation;
   logic mod_rsvd;
   rmcr_dop_t dop;
   rmcr_ook_t ook;
   logic [1:0] if_att;
   logic [4:0] half_db;
   logic [7:0] dev;
   logic [13:0] dev_div;
   logic [6:0] rate;
   logic [13:0] bit_per;
   logic [7:0] floor_v;
   logic [6:0] depth;
   logic [5:0] thr;
   logic thr_evt;
   int error_cnt = 0;
   int n_tests = 0;
   rmcr_mod_t mod_exp[4] = '{RMCR_MOD_RSVD, RMCR_MOD_OOK, RMCR_MOD_FSK, RMCR_MOD_RSVD};
   rmcr_dop_t dop_exp[4] = '{RMCR_DOP_CONT, RMCR_DOP_PKT, RMCR_DOP_BUF, RMCR_DOP_PKT};
   rmcr_ook_t ook_exp[4] = '{RMCR_OOK_FIXED, RMCR_OOK_PEAK, RMCR_OOK_AVG, RMCR_OOK_RSVD};
   logic [7:0] dv[3] = '{8'h00, 8'h55, 8'hff};
   rmcr_radio_t em[5] = '{RMCR_RADIO_TX, RMCR_RADIO_TX, RMCR_RADIO_RX, RMCR_RADIO_RX,
      RMCR_RADIO_STBY};
   logic [6:0] ef[5] = '{7'h0f, 7'h10, 7'h10, 7'h0f, 7'h3f};
   logic ee[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

   radio_modem_config_regs radio_modem_config_regs_inst (
      .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .radio_mode_in(radio_mode),
      .fifo_fill_in(fifo_fill), .modulation_out(modulation), .mod_reserved_out(mod_rsvd),
      .data_op_mode_out(dop), .ook_threshold_type_out(ook), .if_attenuation_out(if_att),
      .if_atten_half_db_out(half_db), .deviation_value_out(dev), .dev_divisor_out(dev_div),
      .rate_divider_value_out(rate), .bit_period_out(bit_per),
      .floor_threshold_value_out(floor_v), .fifo_depth_bytes_out(depth),
      .fifo_fill_threshold_out(thr), .fifo_thr_event_out(thr_evt)
   );
   rmcr_host_model rmcr_host_model_inst (
      .clk_in(mclk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rd)
   );

   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end

   task automatic print_verdict;
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rmcr_host_model_inst.read_reg(a, d);
      chk(16'(d), 16'(exp));
   endtask : rd_chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      rmcr_host_model_inst.write_reg(a, d);
      #1;
   endtask : wr_reg

   initial begin
      repeat (3000) @(posedge mclk_in);
      error_cnt++;
      print_verdict();
   end

   initial begin
      logic [7:0] v;
      logic [1:0] c;
      rst_in <= 1'b1;
      radio_mode <= RMCR_RADIO_STBY;
      fifo_fill <= 7'h00;
      repeat (16) @(posedge mclk_in);
      rst_in <= 1'b0;
      #1;
      chk(16'(modulation), 16'(RMCR_MOD_FSK));
      chk(16'(dop), 16'(RMCR_DOP_CONT));
      chk(16'(ook), 16'(RMCR_OOK_PEAK));
      chk(16'(dev_div), 16'h0080);
      chk(16'(bit_per), 16'h0200);
      chk(16'(floor_v), 16'h000c);
      chk(16'(depth), 16'h0010);
      chk(16'(thr), 16'h000f);
      rd_chk(OFS_FREQ_DEV, 8'h03);
      rd_chk(OFS_BIT_RATE, 8'h07);
      rd_chk(OFS_FLOOR, 8'h0c);
      rd_chk(OFS_FIFO, 8'h0f);
      rd_chk(OFS_DATA_MOD, 8'h88);
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         v = {c, c[1], c, c[0], c};
         wr_reg(OFS_DATA_MOD, v);
         chk(16'(modulation), 16'(mod_exp[i]));
         chk(16'(mod_rsvd), 16'(c == 2'h0 || c == 2'h3));
         chk(16'(dop), 16'(dop_exp[i]));
         chk(16'(ook), 16'(ook_exp[i]));
         chk(16'(if_att), 16'(c));
         chk(16'(half_db), 16'(9 * i));
         rd_chk(OFS_DATA_MOD, v);
      end
      for (int k = 0; k < 3; k++) begin
         wr_reg(OFS_FREQ_DEV, dv[k]);
         wr_reg(OFS_BIT_RATE, dv[k] & 8'h7f);
         wr_reg(OFS_FLOOR, dv[k]);
         chk(16'(dev), 16'(dv[k]));
         chk(16'(dev_div), 16'(32 * (int'(dv[k]) + 1)));
         chk(16'(rate), 16'(dv[k] & 8'h7f));
         chk(16'(bit_per), 16'(64 * (int'(dv[k] & 8'h7f) + 1)));
         chk(16'(floor_v), 16'(dv[k]));
         rd_chk(OFS_FREQ_DEV, dv[k]);
         rd_chk(OFS_BIT_RATE, dv[k] & 8'h7f);
         rd_chk(OFS_FLOOR, dv[k]);
      end
      wr_reg(8'h06, 8'haa);
      rd_chk(8'h06, 8'h00);
      rd_chk(OFS_FREQ_DEV, 8'hff);
      @(posedge mclk_in);
      #1;
      chk(16'(rdata), 16'h0000);
      rmcr_host_model_inst.write_read(OFS_FREQ_DEV, 8'h5a, v);
      chk(16'(v), 16'h005a);
      chk(16'(dev), 16'h005a);
      for (int s = 0; s < 4; s++) begin
         v = {2'(s), 6'(21 * s)};
         wr_reg(OFS_FIFO, v);
         chk(16'(depth), 16'(16 * (s + 1)));
         chk(16'(thr), 16'(21 * s));
         rd_chk(OFS_FIFO, v);
      end
      wr_reg(OFS_FIFO, 8'h0f);
      for (int k = 0; k < 5; k++) begin
         @(posedge mclk_in);
         radio_mode <= em[k];
         fifo_fill <= ef[k];
         @(posedge mclk_in);
         #1;
         chk(16'(thr_evt), 16'(ee[k]));
      end
      wr_reg(OFS_FIFO, 8'hc5);
      chk(16'(thr), 16'h0005);
      @(posedge mclk_in);
      rst_in <= 1'b1;
      @(posedge mclk_in);
      rst_in <= 1'b0;
      rd_chk(OFS_FREQ_DEV, 8'h03);
      rd_chk(OFS_FIFO, 8'h0f);
      print_verdict();
   end
endmodule : radio_modem_config_regs_test
